// >>> core/ctm_map.svh
// Purpose: Offsets, fields, resets and timing of the clock timer block
// Assumes: APB byte addresses = printed offsets
// Notes: Operation list follows
// Operation
// - 8-bit binary prescaler clocked by 256 Hz tick, taps 128 Hz to 1 Hz.
// - 7-bit BCD seconds counter, tens and units, 0 to 59, advanced by 1 Hz.
// - Software reads prescaler taps and BCD seconds at any time.
// - Software can preset the seconds counter.
// - Tap flags set on falling edge of 32, 8, 2, 1 Hz taps.
// - Seconds-overflow flag set when BCD seconds counter overflows.
// - Each timer source gated by its own enable bit.
// - Two-bit priority field selects timer request level 0 to 3.
// - Timer interrupt uses vector address 000028H.
// - Readable display interrupt enable bit, write one enables, zero disables.
// - Display flag set when one-shot or auto display transfer completes.
// - Request only when flag set, enabled, and level above CPU mask.
// - Flags set on their condition regardless of enable and priority.
// - Writing one clears a flag, zero ignored; software clears flag and mask.
// - Timer enables at D7..D3: overflow, 1, 2, 8, 32 Hz.
// - Flags D7..D2: overflow, 1, 2, 8, 32 Hz, display at D2.
// - Enables, flags and priorities reset to zero.
// - Counting only while run bit is one; holds value otherwise.
// - Writing one to clear strobe clears prescaler and seconds; reads zero.
// - Seconds write presets counter and clears prescaler; overflow returns to zero.
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH
`define CTM_OFF_PRIO        16'hFF21
`define CTM_OFF_ENABLE      16'hFF25
`define CTM_OFF_FLAGS       16'hFF29
`define CTM_OFF_CTRL        16'hFF50
`define CTM_OFF_TAPS        16'hFF51
`define CTM_OFF_SECS        16'hFF52
`define CTM_PRIO_DISP_LSB   0
`define CTM_PRIO_TMR_LSB    2
`define CTM_BIT_DISP        2
`define CTM_BIT_TAP32       3
`define CTM_BIT_TAP8        4
`define CTM_BIT_TAP2        5
`define CTM_BIT_TAP1        6
`define CTM_BIT_OVF         7
`define CTM_BIT_RUN         0
`define CTM_BIT_CLR         1
`define CTM_RESET_BYTE      8'h00
`define CTM_VECTOR_ADDR     24'h000028
`define CTM_CLK_HZ          20000000
`define CTM_TICK_HZ         256
`define CTM_TICK_CYCLES     (`CTM_CLK_HZ / `CTM_TICK_HZ)
`endif

// >>> core/ctm_pkg.sv
// Purpose: Types shared by the clock timer block
// Assumes: Constants live in ctm_map.svh
// Notes: Bus request carrier struct
package ctm_pkg;
  typedef struct packed {
    logic        sel;
    logic        en;
    logic        write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } ctm_apb_req_s;
  typedef logic [1:0] ctm_level_t;
endpackage : ctm_pkg

// >>> core/ctm_clock_timer.sv
// Purpose: Clock timer with shared interrupt registers on APB
// Assumes: 20 MHz mclk; tick enable divided from it stands for 256 Hz
// Notes: Zero wait-state APB slave; pslverr on unmapped address
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "ctm_map.svh"
module ctm_clock_timer #(
  parameter int TICK_CYCLES = `CTM_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Display transfer completion pulses, same clock
  input  wire logic        oneshot_done,
  input  wire logic        auto_done,
  // CPU interrupt side
  input  wire logic [1:0]  cpu_mask_level,
  output logic             timer_irq_req,
  output logic [1:0]       timer_irq_level,
  output logic [23:0]      timer_irq_vector,
  output logic             display_irq_req,
  output logic [1:0]       display_irq_level
);

  // Elaboration check: the divider needs at least two cycles a tick
  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
    end
  endgenerate

  // BCD increment with wrap from 59
  function automatic logic [6:0] bcd_inc(input logic [6:0] v);
    logic [6:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r[3:0] = 4'h0;
      r[6:4] = (v[6:4] == 3'h5) ? 3'h0 : v[6:4] + 3'h1;
    end else begin
      r[3:0] = v[3:0] + 4'h1;
    end
    return r;
  endfunction : bcd_inc

  // Next flag state: a set event wins over a write-one clear
  function automatic logic flag_next(input logic q, input logic set, input logic clr);
    return set || (q && !clr);
  endfunction : flag_next

  ctm_pkg::ctm_apb_req_s req;
  assign req = '{sel: psel, en: penable, write: pwrite, addr: paddr, wdata: pwdata};

  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  assign wr_acc = req.sel && req.en && req.write;
  assign rd_acc = req.sel && !req.en && !req.write;
  assign mapped = (req.addr == `CTM_OFF_PRIO) || (req.addr == `CTM_OFF_ENABLE) ||
                  (req.addr == `CTM_OFF_FLAGS) || (req.addr == `CTM_OFF_CTRL) ||
                  (req.addr == `CTM_OFF_TAPS) || (req.addr == `CTM_OFF_SECS);

  logic        wr_prio;
  logic        wr_en;
  logic        wr_flag;
  logic        wr_ctrl;
  logic        wr_secs;
  assign wr_prio = wr_acc && (req.addr == `CTM_OFF_PRIO);
  assign wr_en   = wr_acc && (req.addr == `CTM_OFF_ENABLE);
  assign wr_flag = wr_acc && (req.addr == `CTM_OFF_FLAGS);
  assign wr_ctrl = wr_acc && (req.addr == `CTM_OFF_CTRL);
  assign wr_secs = wr_acc && (req.addr == `CTM_OFF_SECS);

  logic [7:0]  prio_q;
  logic [7:0]  enable_q;
  logic [7:0]  flags_q;
  logic        tap32_irq_enable_q;
  logic        tap8_irq_enable_q;
  logic        tap2_irq_enable_q;
  logic        tap1_irq_enable_q;
  logic        seconds_overflow_enable_q;
  logic        display_irq_enable_q;
  logic        tap32_irq_flag_q;
  logic        tap8_irq_flag_q;
  logic        tap2_irq_flag_q;
  logic        tap1_irq_flag_q;
  logic        seconds_overflow_flag_q;
  logic        display_irq_flag_q;
  logic [7:0]  clr_vec;
  logic        run_q;
  logic [7:0]  presc_q;
  logic [7:0]  presc_d;
  logic [6:0]  secs_q;
  logic [31:0] div_q;
  logic        tick;

  // Priority register, full byte stored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prio_q <= `CTM_RESET_BYTE;
    end else if (wr_prio) begin
      prio_q <= req.wdata[7:0];
    end
  end

  // Overflow enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      seconds_overflow_enable_q <= 1'b0;
    end else if (wr_en) begin
      seconds_overflow_enable_q <= req.wdata[`CTM_BIT_OVF];
    end
  end

  // 1 Hz tap enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tap1_irq_enable_q <= 1'b0;
    end else if (wr_en) begin
      tap1_irq_enable_q <= req.wdata[`CTM_BIT_TAP1];
    end
  end

  // 2 Hz tap enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tap2_irq_enable_q <= 1'b0;
    end else if (wr_en) begin
      tap2_irq_enable_q <= req.wdata[`CTM_BIT_TAP2];
    end
  end

  // 8 Hz tap enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tap8_irq_enable_q <= 1'b0;
    end else if (wr_en) begin
      tap8_irq_enable_q <= req.wdata[`CTM_BIT_TAP8];
    end
  end

  // 32 Hz tap enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tap32_irq_enable_q <= 1'b0;
    end else if (wr_en) begin
      tap32_irq_enable_q <= req.wdata[`CTM_BIT_TAP32];
    end
  end

  // Display completion enable, readable back
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      display_irq_enable_q <= 1'b0;
    end else if (wr_en) begin
      display_irq_enable_q <= req.wdata[`CTM_BIT_DISP];
    end
  end

  // Enable register image, D1..D0 read zero
  assign enable_q = {seconds_overflow_enable_q, tap1_irq_enable_q, tap2_irq_enable_q, tap8_irq_enable_q,
                     tap32_irq_enable_q, display_irq_enable_q, 2'b00};

  // Run control bit
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
    end else if (wr_ctrl) begin
      run_q <= req.wdata[`CTM_BIT_RUN];
    end
  end

  // Tick divider standing for the 256 Hz source
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 32'h0;
      tick  <= 1'b0;
    end else if (div_q == 32'(TICK_CYCLES - 1)) begin
      div_q <= 32'h0;
      tick  <= 1'b1;
    end else begin
      div_q <= div_q + 32'h1;
      tick  <= 1'b0;
    end
  end

  logic clr_strobe;
  logic count_en;
  assign clr_strobe = wr_ctrl && req.wdata[`CTM_BIT_CLR];
  assign count_en   = run_q && tick;
  assign presc_d    = presc_q + 8'h01;

  // Binary prescaler, bit0 = 128 Hz, bit7 = 1 Hz
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      presc_q <= 8'h00;
    end else if (clr_strobe || wr_secs) begin
      presc_q <= 8'h00;
    end else if (count_en) begin
      presc_q <= presc_d;
    end
  end

  // Falling edges of taps, one-cycle pulses
  logic [7:0] fall;
  logic       sec_step;
  logic       ovf_pulse;
  assign fall      = (count_en && !clr_strobe && !wr_secs) ? (presc_q & ~presc_d) : 8'h00;
  assign sec_step  = fall[7];
  assign ovf_pulse = sec_step && (secs_q == 7'h59);

  // BCD seconds counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      secs_q <= 7'h00;
    end else if (clr_strobe) begin
      secs_q <= 7'h00;
    end else if (wr_secs) begin
      secs_q <= req.wdata[6:0];
    end else if (sec_step) begin
      secs_q <= bcd_inc(secs_q);
    end
  end

  logic [7:0] set_vec;
  assign set_vec = {ovf_pulse, fall[7], fall[6], fall[4], fall[2],
                    oneshot_done || auto_done, 2'b00};

  // Write-one clear mask, live only in a flag register write
  assign clr_vec = wr_flag ? req.wdata[7:0] : 8'h00;

  // Overflow flag
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      seconds_overflow_flag_q <= 1'b0;
    end else begin
      seconds_overflow_flag_q <= flag_next(seconds_overflow_flag_q, set_vec[`CTM_BIT_OVF],
                                           clr_vec[`CTM_BIT_OVF]);
    end
  end

  // 1 Hz tap flag
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tap1_irq_flag_q <= 1'b0;
    end else begin
      tap1_irq_flag_q <= flag_next(tap1_irq_flag_q, set_vec[`CTM_BIT_TAP1],
                                   clr_vec[`CTM_BIT_TAP1]);
    end
  end

  // 2 Hz tap flag
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tap2_irq_flag_q <= 1'b0;
    end else begin
      tap2_irq_flag_q <= flag_next(tap2_irq_flag_q, set_vec[`CTM_BIT_TAP2],
                                   clr_vec[`CTM_BIT_TAP2]);
    end
  end

  // 8 Hz tap flag
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tap8_irq_flag_q <= 1'b0;
    end else begin
      tap8_irq_flag_q <= flag_next(tap8_irq_flag_q, set_vec[`CTM_BIT_TAP8],
                                   clr_vec[`CTM_BIT_TAP8]);
    end
  end

  // 32 Hz tap flag
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tap32_irq_flag_q <= 1'b0;
    end else begin
      tap32_irq_flag_q <= flag_next(tap32_irq_flag_q, set_vec[`CTM_BIT_TAP32],
                                    clr_vec[`CTM_BIT_TAP32]);
    end
  end

  // Display completion flag, either transfer kind
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      display_irq_flag_q <= 1'b0;
    end else begin
      display_irq_flag_q <= flag_next(display_irq_flag_q, set_vec[`CTM_BIT_DISP],
                                      clr_vec[`CTM_BIT_DISP]);
    end
  end

  // Flag register image, D1..D0 read zero
  assign flags_q = {seconds_overflow_flag_q, tap1_irq_flag_q, tap2_irq_flag_q, tap8_irq_flag_q,
                    tap32_irq_flag_q, display_irq_flag_q, 2'b00};

  logic       tmr_pending;
  logic [1:0] tmr_lvl;
  logic [1:0] dsp_lvl;
  assign tmr_pending = |(flags_q[7:3] & enable_q[7:3]);
  assign tmr_lvl     = prio_q[`CTM_PRIO_TMR_LSB +: 2];
  assign dsp_lvl     = prio_q[`CTM_PRIO_DISP_LSB +: 2];

  // Registered interrupt requests toward the CPU
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_irq_req     <= 1'b0;
      display_irq_req   <= 1'b0;
      timer_irq_level   <= 2'h0;
      display_irq_level <= 2'h0;
    end else begin
      timer_irq_req     <= tmr_pending && (tmr_lvl > cpu_mask_level);
      display_irq_req   <= flags_q[`CTM_BIT_DISP] && enable_q[`CTM_BIT_DISP] &&
                           (dsp_lvl > cpu_mask_level);
      timer_irq_level   <= tmr_lvl;
      display_irq_level <= dsp_lvl;
    end
  end

  // Fixed vector of the timer request, constant once out of reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_irq_vector <= 24'h000000;
    end else begin
      timer_irq_vector <= `CTM_VECTOR_ADDR;
    end
  end

  // Ready one cycle after setup, error with it on unmapped offsets
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= req.sel && !req.en;
      pslverr <= req.sel && !req.en && !mapped;
    end
  end

  // APB read mux, answers in the access cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0;
    end else begin
      if (rd_acc) begin
        case (req.addr)
          `CTM_OFF_PRIO:   prdata <= {24'h0, prio_q};
          `CTM_OFF_ENABLE: prdata <= {24'h0, enable_q};
          `CTM_OFF_FLAGS:  prdata <= {24'h0, flags_q};
          `CTM_OFF_CTRL:   prdata <= {31'h0, run_q};
          `CTM_OFF_TAPS:   prdata <= {24'h0, presc_q};
          `CTM_OFF_SECS:   prdata <= {25'h0, secs_q};
          default:         prdata <= 32'h0;
        endcase
      end else begin
        prdata <= 32'h0;
      end
    end
  end

endmodule : ctm_clock_timer
`default_nettype wire

// >>> verification/ctm_clock_timer_asserts.sv
// Purpose: Port checks of the clock timer
// Assumes: Zero wait APB slave, registered irq outputs
// Notes: Bound from the bench file
`timescale 1ns/1ns
`default_nettype none
module ctm_clock_timer_asserts (
  // Clock and bus
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupt side
  input wire logic [1:0]  cpu_mask_level,
  input wire logic        timer_irq_req,
  input wire logic [1:0]  timer_irq_level,
  input wire logic [23:0] timer_irq_vector,
  input wire logic        display_irq_req,
  input wire logic [1:0]  display_irq_level
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access) else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside {16'hFF21, 16'hFF25, 16'hFF29,
    16'hFF50, 16'hFF51, 16'hFF52})) else $error("bad error flag");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  a_vector_fixed: assert property ($past(arst_n) |-> timer_irq_vector == 24'h000028) else $error("bad vector");
  a_timer_masked: assert property ($stable(cpu_mask_level) && timer_irq_level <= cpu_mask_level
    |-> !timer_irq_req) else $error("timer req at low level");
  a_disp_masked: assert property ($stable(cpu_mask_level) && display_irq_level <= cpu_mask_level
    |-> !display_irq_req) else $error("display req at low level");
  a_timer_rise: assert property ($rose(timer_irq_req) |-> timer_irq_level > $past(cpu_mask_level))
    else $error("timer req rose under mask");
  a_disp_rise: assert property ($rose(display_irq_req) |-> display_irq_level > $past(cpu_mask_level))
    else $error("display req rose under mask");
endmodule : ctm_clock_timer_asserts
`default_nettype wire

// >>> verification/ctm_cpu_model.sv
// Purpose: CPU side stand-in: mask level and display completion
// Assumes: Completion pulses one mclk wide
// Notes: Driven through its tasks
`timescale 1ns/1ns
`default_nettype none
module ctm_cpu_model (
  // Clock
  input  wire logic  mclk,
  // Toward the timer block
  output logic       oneshot_done,
  output logic       auto_done,
  output logic [1:0] cpu_mask_level
);
  // Idle levels
  initial begin
    oneshot_done = 1'b0;
    auto_done = 1'b0;
    cpu_mask_level = 2'h0;
  end
  // One-cycle completion of either transfer kind
  task automatic done_pulse(input logic kind);
    @(posedge mclk);
    if (kind) auto_done <= 1'b1; else oneshot_done <= 1'b1;
    @(posedge mclk);
    auto_done <= 1'b0;
    oneshot_done <= 1'b0;
  endtask : done_pulse
  // Mask change by software
  task automatic set_mask(input logic [1:0] lvl);
    @(posedge mclk);
    cpu_mask_level <= lvl;
  endtask : set_mask
endmodule : ctm_cpu_model
`default_nettype wire

// >>> verification/clock_timer_with_irq_regs_bench.sv
// Purpose: Self-checking bench of the clock timer block
// Assumes: Four cycles a tick, so a second is 1024 cycles
// Notes: Reads are checked from a queue by a watcher
`timescale 1ns/1ns
`default_nettype none
module clock_timer_with_irq_regs_bench;
  localparam int TICKS = 4;
  logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, oneshot_done, auto_done, timer_irq_req, display_irq_req;
  logic [1:0] cpu_mask_level, timer_irq_level, display_irq_level;
  logic [23:0] timer_irq_vector;
  logic [7:0] r;
  logic [32:0] exp_q[$];
  logic [15:0] regs [6] = '{16'hFF21, 16'hFF25, 16'hFF29, 16'hFF50, 16'hFF51, 16'hFF52};
  int num_errors = 0, checks = 0, cycles = 0;
  always #25 mclk = ~mclk;
  ctm_clock_timer #(.TICK_CYCLES(TICKS)) ctm_clock_timer_i (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .oneshot_done, .auto_done, .cpu_mask_level, .timer_irq_req,
    .timer_irq_level, .timer_irq_vector, .display_irq_req, .display_irq_level);
  ctm_cpu_model ctm_cpu_model_i (.mclk, .oneshot_done, .auto_done, .cpu_mask_level);
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic cmp(input string what, input logic [32:0] exp, input logic [32:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Interrupt outputs, looked at mid-cycle once settled
  task automatic cmp_irq(input logic t_req, input logic [1:0] t_lvl, input logic d_req, input logic [1:0] d_lvl);
    repeat (3) @(negedge mclk);
    checks++;
    if ({timer_irq_req, timer_irq_level, display_irq_req, display_irq_level, timer_irq_vector} !==
        {t_req, t_lvl, d_req, d_lvl, 24'h000028}) begin
      num_errors++;
      $display("[ERR] irq expected %h seen %h", {t_req, t_lvl, d_req, d_lvl, 24'h000028},
        {timer_irq_req, timer_irq_level, display_irq_req, display_irq_level, timer_irq_vector});
    end
  endtask : cmp_irq
  // Setup then access, held until ready
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic err);
    if (!wr) exp_q.push_back({err, 24'h0, d});
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Read watcher and hang limit
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (pready === 1'b1 && pwrite === 1'b0) cmp($sformatf("read %h", paddr), exp_q.pop_front(), {pslverr, prdata});
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(65));
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (regs[i]) apb(0, regs[i], 8'h00, 0);
    apb(0, 16'hFF30, 8'h00, 1);
    r = 8'($urandom);
    apb(1, 16'hFF21, r, 0);
    apb(0, 16'hFF21, r, 0);
    apb(1, 16'hFF25, 8'hFF, 0);
    apb(0, 16'hFF25, 8'hFC, 0);
    apb(1, 16'hFF25, 8'h04, 0);
    apb(0, 16'hFF25, 8'h04, 0);
    // Clear strobe while stopped
    apb(1, 16'hFF50, 8'h02, 0);
    apb(0, 16'hFF50, 8'h00, 0);
    apb(0, 16'hFF51, 8'h00, 0);
    apb(0, 16'hFF52, 8'h00, 0);
    // Preset while stopped holds, then resumes
    apb(1, 16'hFF52, 8'h30, 0);
    repeat (1500) @(posedge mclk);
    apb(0, 16'hFF52, 8'h30, 0);
    apb(0, 16'hFF51, 8'h00, 0);
    apb(1, 16'hFF50, 8'h01, 0);
    repeat (1536) @(posedge mclk);
    apb(0, 16'hFF52, 8'h31, 0);
    // BCD carry, then wrap with overflow
    apb(1, 16'hFF52, 8'h09, 0);
    repeat (1536) @(posedge mclk);
    apb(0, 16'hFF52, 8'h10, 0);
    apb(1, 16'hFF52, 8'h59, 0);
    repeat (1536) @(posedge mclk);
    apb(0, 16'hFF52, 8'h00, 0);
    apb(0, 16'hFF29, 8'hF8, 0);
    cmp_irq(1'b0, r[3:2], 1'b0, r[1:0]);
    apb(1, 16'hFF50, 8'h00, 0);
    apb(1, 16'hFF29, 8'hFF, 0);
    apb(0, 16'hFF29, 8'h00, 0);
    // Display completion and its request
    ctm_cpu_model_i.done_pulse(1'b0);
    apb(0, 16'hFF29, 8'h04, 0);
    apb(1, 16'hFF29, 8'h00, 0);
    apb(0, 16'hFF29, 8'h04, 0);
    apb(1, 16'hFF21, 8'h02, 0);
    ctm_cpu_model_i.set_mask(2'h1);
    cmp_irq(1'b0, 2'h0, 1'b1, 2'h2);
    ctm_cpu_model_i.set_mask(2'h2);
    cmp_irq(1'b0, 2'h0, 1'b0, 2'h2);
    ctm_cpu_model_i.set_mask(2'h0);
    apb(1, 16'hFF29, 8'h04, 0);
    cmp_irq(1'b0, 2'h0, 1'b0, 2'h2);
    ctm_cpu_model_i.done_pulse(1'b1);
    cmp_irq(1'b0, 2'h0, 1'b1, 2'h2);
    apb(1, 16'hFF25, 8'h00, 0);
    cmp_irq(1'b0, 2'h0, 1'b0, 2'h2);
    apb(1, 16'hFF29, 8'h04, 0);
    // Timer request from the 32 Hz tap
    apb(1, 16'hFF21, 8'h0C, 0);
    apb(1, 16'hFF25, 8'h08, 0);
    apb(1, 16'hFF50, 8'h01, 0);
    repeat (100) @(posedge mclk);
    cmp_irq(1'b1, 2'h3, 1'b0, 2'h0);
    ctm_cpu_model_i.set_mask(2'h3);
    cmp_irq(1'b0, 2'h3, 1'b0, 2'h0);
    apb(1, 16'hFF50, 8'h00, 0);
    ctm_cpu_model_i.set_mask(2'h0);
    apb(1, 16'hFF29, 8'hFF, 0);
    cmp_irq(1'b0, 2'h3, 1'b0, 2'h0);
    // Reset while stopped
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    cmp_irq(1'b0, 2'h0, 1'b0, 2'h0);
    foreach (regs[i]) apb(0, regs[i], 8'h00, 0);
    complete_run();
  end
endmodule : clock_timer_with_irq_regs_bench
bind ctm_clock_timer ctm_clock_timer_asserts ctm_clock_timer_asserts_i (.mclk, .arst_n, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .cpu_mask_level, .timer_irq_req, .timer_irq_level, .timer_irq_vector,
  .display_irq_req, .display_irq_level);
`default_nettype wire
